// *** mcell_pkg.sv ***
// Shared constants, types and helpers for the macrocell configuration logic.
package mcell_pkg;

  // ==========================================================================
  // Geometry.
  localparam int NUM_CELLS = 8;
  localparam int PT_PER_CELL = 8;
  localparam int NUM_PT = 64;
  localparam int NUM_IN = 8;
  localparam int ARRAY_COLS = 32;
  localparam int PT_ENABLE = 0;
  localparam int EDGE_LOW = 0;
  localparam int EDGE_HIGH = 7;
  localparam int NOFB_A = 3;
  localparam int NOFB_B = 4;

  // ==========================================================================
  // Timing.
  localparam int CLK_PERIOD_NS = 5;
  localparam int STANDBY_NS = 50;
  localparam int STANDBY_CYC = (STANDBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] STANDBY_CNT = 4'(STANDBY_CYC);

  // ==========================================================================
  // Register byte offsets and address fields.
  localparam int ADR_W = 10;
  localparam logic [9:0] OFS_CONFIG = 10'h000;
  localparam logic [9:0] OFS_STATUS = 10'h004;
  localparam logic [9:0] OFS_SECURE = 10'h008;
  localparam logic [9:0] OFS_ERASE = 10'h00c;
  localparam logic [9:0] OFS_PRELOAD = 10'h010;
  localparam logic [9:0] OFS_PINS = 10'h014;
  localparam logic [9:0] OFS_FORMS = 10'h018;
  localparam logic [9:0] OFS_SIG_LO = 10'h020;
  localparam logic [9:0] OFS_SIG_HI = 10'h024;
  localparam int SIG_ADDR_BIT = 2;
  localparam int PAGE_LSB = 8;
  localparam int PAGE_W = 2;
  localparam logic [1:0] ARRAY_PAGE = 2'h1;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 6;

  // ==========================================================================
  // Register fields.
  localparam int CFG_REG_ALLOW_BIT = 0;
  localparam int CFG_EMUL_BIT = 1;
  localparam int CFG_ZP_BIT = 2;
  localparam int CFG_FORM_LSB = 8;
  localparam int CFG_POL_LSB = 16;
  localparam int STAT_Q_LSB = 0;
  localparam int STAT_STANDBY_BIT = 8;
  localparam int STAT_SECURE_BIT = 9;
  localparam int STAT_PIN_LSB = 16;
  localparam int SECURE_SET_BIT = 0;
  localparam int ERASE_GO_BIT = 0;
  localparam int FORM_W = 3;

  // ==========================================================================
  // Types.
  typedef enum logic [2:0] {
    FORM_REG,
    FORM_CIO_REG,
    FORM_COUT,
    FORM_DIN,
    FORM_CIO,
    FORM_NONE
  } cell_form_t;

  typedef struct packed {
    logic [7:0] output_polarity_bit;
    logic [7:0] cell_form_select_bit;
    logic zero_power_en;
    logic emulation_select_bit;
    logic register_allow_bit;
  } cfg_t;

  localparam cfg_t CFG_RESET = '0;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic [7:0] ded;
    logic clk_pin;
    logic oe_n_pin;
    logic [7:0] io;
  } pins_in_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } pins_out_t;

  // Merges write data into an old word under the byte enables.
  function automatic logic [31:0] sel_merge(logic [31:0] old, logic [31:0] din,
                                            logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = din[8*b +: 8];
      end
    end
    return r;
  endfunction

endpackage

// *** sig_mem.sv ***
// Signature word memory with registered read data.
module sig_mem (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Write control.
  input wire logic wr_en,
  input wire logic [3:0] wr_sel,
  input wire logic [31:0] wr_data,
  // Word address.
  input wire logic addr,
  // Read data.
  output logic [31:0] rd_data
);

  typedef struct packed {
    logic [1:0][31:0] mem;
    logic [31:0] rd;
  } sig_state_t;

  sig_state_t st;
  sig_state_t next_st;

  always_comb begin
    next_st = st;
    if (wr_en) begin
      next_st.mem[addr] = mcell_pkg::sel_merge(st.mem[addr], wr_data, wr_sel);
    end
    next_st.rd = st.mem[addr];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd;

endmodule // sig_mem

// *** macrocell_config_logic.sv ***
// Eight-cell configurable output macrocell array with a Wishbone register port.

// Function
// [R1] Each cell takes one of five forms; the code also gives a sixth, FORM_NONE, for the other three settings.
// [R2] Buffer enable follows form: pin, term, on, off.
// [R3] Dedicated input uses neighbour; edges use pins.
// [R4] Config holds two global, sixteen local bits; the code also holds a third global bit, zero_power_en.
// [R5] Globals: register allow and emulation family.
// [R6] Local select plus emulation picks form; polarity.
// [R7] Four muxes steered; edges use register allow.
// [R8] Registered form: eight terms, Q feedback, pin enable.
// [R9] Register captures on clock pin rising edge.
// [R10] Combinatorial output: eight terms, limited feedback.
// [R11] Non-registered I/O: seven terms, term enable.
// [R12] Registered-device I/O: seven terms, pin feedback.
// [R13] Dedicated input: buffer off, neighbour feedback.
// [R14] Exclusive-OR sets output polarity.
// [R15] Flip-flops clear low; registered outputs read high.
// [R16] Registers preloadable with arbitrary values.
// [R17] Security bit blocks readback; erase clears it.
// [R18] Sixty-four bit signature always readable.
// [R19] Quiet inputs enter standby; outputs held.
// [R20] Empty term high; contradictory term low.
// [R21] Clock and enable pins: inputs or controls.
// [R22] Any input change leaves standby at once.
// [R23] Configuration treated as static while running.
module macrocell_config_logic (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Wishbone register port.
  input wire mcell_pkg::wb_req_t wb_i,
  output mcell_pkg::wb_rsp_t wb_o,
  // Device pins.
  input wire mcell_pkg::pins_in_t pin_i,
  output mcell_pkg::pins_out_t pin_o,
  // Status.
  output logic standby
);

  // ==========================================================================
  // State.
  typedef struct packed {
    logic ack;
    logic rd_sig;
    logic [31:0] rdat;
    mcell_pkg::cfg_t cfg;
    logic secure;
    logic [7:0] q;
    logic clk_prev;
    mcell_pkg::pins_in_t pin_prev;
    logic [3:0] quiet;
    logic standby;
    mcell_pkg::pins_out_t held;
    logic [63:0][31:0] and_array;
  } state_t;

  state_t st;
  state_t next_st;

  // ==========================================================================
  // Helpers.
  function automatic mcell_pkg::cell_form_t decode_form(logic ra, logic es, logic fs);
    case ({ra, es, fs})
      3'h2: return mcell_pkg::FORM_REG;
      3'h3: return mcell_pkg::FORM_CIO_REG;
      3'h4: return mcell_pkg::FORM_COUT;
      3'h5: return mcell_pkg::FORM_DIN;
      3'h7: return mcell_pkg::FORM_CIO;
      default: return mcell_pkg::FORM_NONE;
    endcase
  endfunction

  function automatic logic adj_pin(logic [7:0] io, int i);
    return (i < mcell_pkg::NOFB_B) ? io[i + 1] : io[i - 1];
  endfunction

  function automatic logic and_term(logic [31:0] mask, logic [31:0] cols);
    return &(~mask | cols);
  endfunction

  function automatic logic [31:0] cfg_to_word(mcell_pkg::cfg_t c);
    logic [31:0] w;
    w = '0;
    w[mcell_pkg::CFG_REG_ALLOW_BIT] = c.register_allow_bit;
    w[mcell_pkg::CFG_EMUL_BIT] = c.emulation_select_bit;
    w[mcell_pkg::CFG_ZP_BIT] = c.zero_power_en;
    w[mcell_pkg::CFG_FORM_LSB +: 8] = c.cell_form_select_bit;
    w[mcell_pkg::CFG_POL_LSB +: 8] = c.output_polarity_bit;
    return w;
  endfunction

  function automatic mcell_pkg::cfg_t word_to_cfg(logic [31:0] w);
    mcell_pkg::cfg_t c;
    c.register_allow_bit = w[mcell_pkg::CFG_REG_ALLOW_BIT];
    c.emulation_select_bit = w[mcell_pkg::CFG_EMUL_BIT];
    c.zero_power_en = w[mcell_pkg::CFG_ZP_BIT];
    c.cell_form_select_bit = w[mcell_pkg::CFG_FORM_LSB +: 8];
    c.output_polarity_bit = w[mcell_pkg::CFG_POL_LSB +: 8];
    return c;
  endfunction

  // ==========================================================================
  // Macrocell datapath.
  mcell_pkg::cell_form_t form [mcell_pkg::NUM_CELLS];
  logic [7:0] fb;
  logic [7:0] sum;
  logic [7:0] en;
  logic [7:0] xo;
  logic [31:0] cols;
  logic [63:0] pt;
  logic [23:0] form_word;
  logic all_sum;
  logic io_sum;
  logic reg_allow;
  logic emul_sel;
  mcell_pkg::pins_out_t live;

  assign reg_allow = st.cfg.register_allow_bit;
  assign emul_sel = st.cfg.emulation_select_bit;

  always_comb begin
    fb = '0;
    sum = '0;
    en = '0;
    xo = '0;
    cols = '0;
    pt = '0;
    form_word = '0;
    all_sum = 1'b0;
    io_sum = 1'b0;
    live = '0;
    for (int i = 0; i < mcell_pkg::NUM_CELLS; i++) begin
      form[i] = decode_form(reg_allow, emul_sel, st.cfg.cell_form_select_bit[i]); // [R1] [R5] [R6]
      form_word[i*mcell_pkg::FORM_W +: mcell_pkg::FORM_W] = form[i];
    end
    for (int i = 0; i < mcell_pkg::NUM_CELLS; i++) begin
      case (form[i])
        mcell_pkg::FORM_REG: begin
          fb[i] = st.q[i]; // [R8]
        end
        mcell_pkg::FORM_COUT: begin
          if (i == mcell_pkg::NOFB_A || i == mcell_pkg::NOFB_B) begin
            fb[i] = 1'b0; // [R10]
          end else begin
            fb[i] = adj_pin(pin_i.io, i); // [R10]
          end
        end
        mcell_pkg::FORM_DIN: begin
          fb[i] = adj_pin(pin_i.io, i); // [R3] [R13]
        end
        default: begin
          fb[i] = pin_i.io[i]; // [R11] [R12]
        end
      endcase
      if (reg_allow && i == mcell_pkg::EDGE_LOW) begin
        fb[i] = pin_i.oe_n_pin; // [R3] [R7] [R21]
      end
      if (reg_allow && i == mcell_pkg::EDGE_HIGH) begin
        fb[i] = pin_i.clk_pin; // [R3] [R7] [R21]
      end
    end
    for (int k = 0; k < mcell_pkg::NUM_IN; k++) begin
      cols[2*k] = pin_i.ded[k];
      cols[2*k+1] = ~pin_i.ded[k];
      cols[2*(k+mcell_pkg::NUM_IN)] = fb[k];
      cols[2*(k+mcell_pkg::NUM_IN)+1] = ~fb[k];
    end
    for (int p = 0; p < mcell_pkg::NUM_PT; p++) begin
      pt[p] = and_term(st.and_array[p], cols); // [R20]
    end
    for (int i = 0; i < mcell_pkg::NUM_CELLS; i++) begin
      all_sum = |pt[i*mcell_pkg::PT_PER_CELL +: mcell_pkg::PT_PER_CELL];
      io_sum = |pt[i*mcell_pkg::PT_PER_CELL + 1 +: mcell_pkg::PT_PER_CELL - 1];
      case (form[i])
        mcell_pkg::FORM_REG: begin
          sum[i] = all_sum; // [R7] [R8]
          en[i] = ~pin_i.oe_n_pin; // [R2] [R8] [R21]
        end
        mcell_pkg::FORM_COUT: begin
          sum[i] = all_sum; // [R10]
          en[i] = 1'b1; // [R2]
        end
        mcell_pkg::FORM_CIO_REG, mcell_pkg::FORM_CIO: begin
          sum[i] = io_sum; // [R11] [R12]
          en[i] = pt[i*mcell_pkg::PT_PER_CELL + mcell_pkg::PT_ENABLE]; // [R2] [R11] [R12]
        end
        default: begin
          sum[i] = 1'b0;
          en[i] = 1'b0; // [R2] [R13]
        end
      endcase
      xo[i] = sum[i] ^ st.cfg.output_polarity_bit[i]; // [R14]
      if (form[i] == mcell_pkg::FORM_REG) begin
        live.out[i] = ~st.q[i]; // [R15]
      end else begin
        live.out[i] = ~xo[i]; // [R14] [R15]
      end
      live.oe_n[i] = ~en[i];
    end
  end

  // ==========================================================================
  // Standby hold and pin outputs.
  logic activity;
  logic clk_rise;

  assign activity = (pin_i != st.pin_prev);
  assign clk_rise = pin_i.clk_pin & ~st.clk_prev;
  assign pin_o = (st.standby && !activity) ? st.held : live; // [R19] [R22]
  assign standby = st.standby;

  // ==========================================================================
  // Register decode.
  logic bus_req;
  logic bus_wr;
  logic sig_hit;
  logic array_hit;
  logic [5:0] idx;
  logic [31:0] read_word;
  logic [31:0] sig_rd;

  assign bus_req = wb_i.cyc & wb_i.stb & ~st.ack;
  assign bus_wr = bus_req & wb_i.we;
  assign sig_hit = (wb_i.adr == mcell_pkg::OFS_SIG_LO) || (wb_i.adr == mcell_pkg::OFS_SIG_HI);
  assign array_hit = (wb_i.adr[mcell_pkg::PAGE_LSB +: mcell_pkg::PAGE_W] == mcell_pkg::ARRAY_PAGE);
  assign idx = wb_i.adr[mcell_pkg::IDX_LSB +: mcell_pkg::IDX_W];

  always_comb begin
    read_word = '0;
    case (wb_i.adr)
      mcell_pkg::OFS_CONFIG: begin
        read_word = cfg_to_word(st.cfg);
      end
      mcell_pkg::OFS_STATUS: begin
        read_word[mcell_pkg::STAT_Q_LSB +: 8] = st.q;
        read_word[mcell_pkg::STAT_STANDBY_BIT] = st.standby;
        read_word[mcell_pkg::STAT_SECURE_BIT] = st.secure;
        read_word[mcell_pkg::STAT_PIN_LSB +: 8] = pin_o.out;
      end
      mcell_pkg::OFS_SECURE: begin
        read_word[mcell_pkg::SECURE_SET_BIT] = st.secure;
      end
      mcell_pkg::OFS_PRELOAD: begin
        read_word[7:0] = st.q;
      end
      mcell_pkg::OFS_PINS: begin
        read_word[17:0] = pin_i;
      end
      mcell_pkg::OFS_FORMS: begin
        read_word[23:0] = form_word;
      end
      default: begin
        if (array_hit && !st.secure) begin
          read_word = st.and_array[idx]; // [R17]
        end
      end
    endcase
  end

  sig_mem u_sig_mem (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(bus_wr & sig_hit),
    .wr_sel(wb_i.sel),
    .wr_data(wb_i.dat),
    .addr(wb_i.adr[mcell_pkg::SIG_ADDR_BIT]),
    .rd_data(sig_rd)
  );

  // ==========================================================================
  // Next state.
  always_comb begin
    next_st = st;
    next_st.clk_prev = pin_i.clk_pin;
    next_st.pin_prev = pin_i;
    for (int i = 0; i < mcell_pkg::NUM_CELLS; i++) begin
      if (form[i] == mcell_pkg::FORM_REG && clk_rise) begin
        next_st.q[i] = xo[i]; // [R9]
      end
    end
    if (activity || !st.cfg.zero_power_en) begin
      next_st.quiet = '0;
      next_st.standby = 1'b0; // [R22]
    end else begin
      if (st.quiet != mcell_pkg::STANDBY_CNT) begin
        next_st.quiet = st.quiet + 4'h1;
      end
      next_st.standby = (next_st.quiet == mcell_pkg::STANDBY_CNT); // [R19]
    end
    if (!st.standby) begin
      next_st.held = live; // [R19]
    end
    next_st.ack = bus_req;
    if (bus_req) begin
      next_st.rd_sig = sig_hit; // [R18]
    end
    if (bus_req && !wb_i.we) begin
      next_st.rdat = read_word;
    end
    if (bus_wr) begin
      case (wb_i.adr)
        mcell_pkg::OFS_CONFIG: begin
          next_st.cfg = word_to_cfg(mcell_pkg::sel_merge(cfg_to_word(st.cfg), wb_i.dat,
                                                          wb_i.sel)); // [R4] [R23]
        end
        mcell_pkg::OFS_SECURE: begin
          if (wb_i.sel[0] && wb_i.dat[mcell_pkg::SECURE_SET_BIT]) begin
            next_st.secure = 1'b1; // [R17]
          end
        end
        mcell_pkg::OFS_ERASE: begin
          if (wb_i.sel[0] && wb_i.dat[mcell_pkg::ERASE_GO_BIT]) begin
            next_st.and_array = '0;
            next_st.cfg = mcell_pkg::CFG_RESET;
            next_st.secure = 1'b0; // [R17]
          end
        end
        mcell_pkg::OFS_PRELOAD: begin
          if (wb_i.sel[0]) begin
            next_st.q = wb_i.dat[7:0]; // [R16]
          end
        end
        default: begin
          if (array_hit) begin
            next_st.and_array[idx] = mcell_pkg::sel_merge(st.and_array[idx], wb_i.dat,
                                                          wb_i.sel);
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // State register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0; // [R15]
    end else begin
      st <= next_st;
    end
  end

  assign wb_o = {st.ack, (st.rd_sig ? sig_rd : st.rdat)};

endmodule // macrocell_config_logic

// *** mcell_props.sv ***
// Checker that watches the macrocell array ports.
module mcell_props (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Watched ports.
  input wire mcell_pkg::wb_req_t wb_i,
  input wire mcell_pkg::wb_rsp_t wb_o,
  input wire mcell_pkg::pins_in_t pin_i,
  input wire mcell_pkg::pins_out_t pin_o,
  input wire logic standby
);
  // ====================
  // Helper logic.
  logic take_rd;
  logic [4:0] quiet;
  mcell_pkg::pins_in_t prev_pin;
  assign take_rd = wb_i.cyc && wb_i.stb && !wb_i.we && !wb_o.ack;
  always_ff @(posedge clk) begin
    prev_pin <= pin_i;
    if (!rst_n || pin_i != prev_pin) begin
      quiet <= 5'h0;
    end else if (quiet != 5'h1f) begin
      quiet <= quiet + 5'h1;
    end
  end
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ====================
  // Properties.
  property p_ack_resp;
    wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("request not answered");
  property p_ack_pulse;
    wb_o.ack |=> !wb_o.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    $rose(wb_o.ack) |-> $past(wb_i.cyc && wb_i.stb);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_reset_out;
    $rose(rst_n) |-> pin_o.oe_n == 8'hff && pin_o.out == 8'hff && !standby;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("pins wrong after reset");
  property p_pins_read;
    take_rd && wb_i.adr == mcell_pkg::OFS_PINS |=> wb_o.dat[17:0] == $past(pin_i);
  endproperty
  a_pins_read: assert property (p_pins_read) else $error("pin readback wrong");
  property p_status_out;
    take_rd && wb_i.adr == mcell_pkg::OFS_STATUS |=> wb_o.dat[23:16] == $past(pin_o.out);
  endproperty
  a_status_out: assert property (p_status_out) else $error("status output field wrong");
  property p_sb_hold;
    standby && $stable(pin_i) |-> $stable(pin_o);
  endproperty
  a_sb_hold: assert property (p_sb_hold) else $error("outputs moved in standby");
  property p_sb_wake;
    standby && !$stable(pin_i) |=> !standby;
  endproperty
  a_sb_wake: assert property (p_sb_wake) else $error("standby kept after input change");
  property p_sb_quiet;
    $rose(standby) |-> quiet >= {1'b0, mcell_pkg::STANDBY_CNT};
  endproperty
  a_sb_quiet: assert property (p_sb_quiet) else $error("standby entered too early");
endmodule // mcell_props

bind macrocell_config_logic mcell_props u_props (.clk(clk), .rst_n(rst_n), .wb_i(wb_i),
  .wb_o(wb_o), .pin_i(pin_i), .pin_o(pin_o), .standby(standby));

// *** board_model.sv ***
// Board model that resolves the eight pulled-up I/O wires.
module board_model (
  // Device side.
  input wire mcell_pkg::pins_out_t pin_o,
  // Resolved wires.
  output logic [7:0] io
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_o.oe_n[i]) begin
        io[i] = pin_o.out[i];
      end else begin
        io[i] = 1'b1;
      end
    end
  end
endmodule // board_model

// *** tb_top.sv ***
// Self-checking testbench for the macrocell array.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Signals.
  logic clk;
  logic rst_n;
  mcell_pkg::wb_req_t wb_i;
  mcell_pkg::wb_rsp_t wb_o;
  mcell_pkg::pins_in_t pin_i;
  mcell_pkg::pins_out_t pin_o;
  logic standby;
  logic [7:0] ded;
  logic clk_pin;
  logic oe_n_pin;
  logic [7:0] io;
  logic [31:0] rd;
  int fail_count;
  int samples_checked;
  assign pin_i = {ded, clk_pin, oe_n_pin, io};
  macrocell_config_logic DUT (.clk(clk), .rst_n(rst_n), .wb_i(wb_i), .wb_o(wb_o),
    .pin_i(pin_i), .pin_o(pin_o), .standby(standby));
  board_model u_board (.pin_o(pin_o), .io(io));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ====================
  // Shared tasks.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [9:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk);
    wb_i <= {1'b1, 1'b1, we, adr, 4'hf, dat};
    do begin
      @(posedge clk);
      n++;
    end while (wb_o.ack !== 1'b1 && n < 20);
    rd = wb_o.dat;
    wb_i <= '0;
    if (n >= 20) begin
      chk("bus answer", 32'h1, 32'h0);
      end_sim();
    end
  endtask
  task automatic rchk(input string what, input logic [9:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    chk(what, exp, rd);
  endtask
  function automatic logic [31:0] cfgw(logic ra, logic es, logic zp, logic [7:0] sl,
                                       logic [7:0] pol);
    return {8'h0, pol, sl, 5'h0, zp, es, ra};
  endfunction
  // ====================
  // Scenarios.
  task automatic s_reset();
    rchk("config", mcell_pkg::OFS_CONFIG, 32'h0);
    rchk("status", mcell_pkg::OFS_STATUS, 32'h00ff0000);
    rchk("forms", mcell_pkg::OFS_FORMS, 32'h00b6db6d);
    rchk("unmapped", 10'h3fc, 32'h0);
    rchk("pins", mcell_pkg::OFS_PINS, {14'h0, ded, clk_pin, oe_n_pin, 8'hff});
  endtask
  task automatic s_forms();
    logic [2:0] c [7] = '{3'b010, 3'b011, 3'b100, 3'b101, 3'b111, 3'b000, 3'b110};
    logic [2:0] f [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5};
    logic [7:0] e [7] = '{8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'hff};
    for (int k = 0; k < 7; k++) begin
      wb(1'b1, mcell_pkg::OFS_CONFIG, cfgw(c[k][2], c[k][1], 1'b0, {8{c[k][0]}}, 8'hff));
      rchk("forms", mcell_pkg::OFS_FORMS, {8'h0, {8{f[k]}}});
      @(negedge clk);
      chk("enable", {24'h0, e[k]}, {24'h0, pin_o.oe_n});
      if (e[k] == 8'h00) begin
        chk("out", 32'hff, {24'h0, pin_o.out});
      end
    end
    wb(1'b1, mcell_pkg::OFS_CONFIG, cfgw(1'b1, 1'b0, 1'b0, 8'h00, 8'h0f));
    @(negedge clk);
    chk("polarity", 32'h0f, {24'h0, pin_o.out});
  endtask
  task automatic s_edge();
    wb(1'b1, mcell_pkg::OFS_CONFIG, cfgw(1'b1, 1'b0, 1'b0, 8'h01, 8'hff));
    for (int n = 8; n < 16; n++) begin
      wb(1'b1, 10'h100 + 10'(4 * n), (n == 8) ? 32'h0001_0000 : 32'h3);
      wb(1'b1, 10'h100 + 10'(4 * (n + 40)), (n == 8) ? 32'h4000_0000 : 32'h3);
    end
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      oe_n_pin <= v[0];
      clk_pin <= ~v[0];
      @(negedge clk);
      chk("edge feedback", {31'h0, v[0]}, {31'h0, pin_o.out[1]});
      chk("clock feedback", {31'h0, ~v[0]}, {31'h0, pin_o.out[6]});
      chk("input buffer", 32'h1, {31'h0, pin_o.oe_n[0]});
    end
  endtask
  task automatic s_reg();
    wb(1'b1, mcell_pkg::OFS_ERASE, 32'h1);
    rchk("erased config", mcell_pkg::OFS_CONFIG, 32'h0);
    wb(1'b1, mcell_pkg::OFS_CONFIG, cfgw(1'b0, 1'b1, 1'b0, 8'h00, 8'h00));
    oe_n_pin <= 1'b0;
    @(negedge clk);
    chk("reg out", 32'h00ff, {16'h0, pin_o.oe_n, pin_o.out});
    wb(1'b1, mcell_pkg::OFS_PRELOAD, 32'h5a);
    rchk("preload", mcell_pkg::OFS_STATUS, 32'h00a5005a);
    rchk("preload read", mcell_pkg::OFS_PRELOAD, 32'h5a);
    @(posedge clk);
    clk_pin <= 1'b1;
    repeat (3) @(posedge clk);
    clk_pin <= 1'b0;
    @(negedge clk);
    chk("captured", 32'h0000, {16'h0, pin_o.oe_n, pin_o.out});
    @(posedge clk);
    oe_n_pin <= 1'b1;
    @(negedge clk);
    chk("pin disable", 32'hff00, {16'h0, pin_o.oe_n, pin_o.out});
  endtask
  task automatic s_secure();
    wb(1'b1, 10'h100, 32'h3);
    wb(1'b1, mcell_pkg::OFS_SIG_LO, 32'h1234_5678);
    wb(1'b1, mcell_pkg::OFS_SIG_HI, 32'h9abc_def0);
    rchk("array open", 10'h100, 32'h3);
    wb(1'b1, mcell_pkg::OFS_SECURE, 32'h1);
    rchk("array locked", 10'h100, 32'h0);
    rchk("secure flag", mcell_pkg::OFS_SECURE, 32'h1);
    rchk("sig lo", mcell_pkg::OFS_SIG_LO, 32'h1234_5678);
    rchk("sig hi", mcell_pkg::OFS_SIG_HI, 32'h9abc_def0);
    wb(1'b1, mcell_pkg::OFS_ERASE, 32'h1);
    rchk("secure cleared", mcell_pkg::OFS_SECURE, 32'h0);
    rchk("array erased", 10'h100, 32'h0);
  endtask
  task automatic s_standby();
    int n;
    wb(1'b1, mcell_pkg::OFS_CONFIG, cfgw(1'b1, 1'b0, 1'b1, 8'h00, 8'hff));
    @(posedge clk);
    ded <= 8'h01;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (standby !== 1'b1 && n < 40);
    chk("quiet cycles", 32'h1, {31'h0, (n >= 9 && n <= 13)});
    if (n >= 40) begin
      end_sim();
    end
    wb(1'b0, mcell_pkg::OFS_STATUS, 32'h0);
    chk("standby flag", 32'h100, rd & 32'h100);
    @(posedge clk);
    ded <= 8'h00;
    @(posedge clk);
    @(negedge clk);
    chk("wake", 32'h0, {31'h0, standby});
  endtask
  // ====================
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    wb_i = '0;
    ded = 8'h00;
    clk_pin = 1'b0;
    oe_n_pin = 1'b1;
    fail_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    s_reset();
    s_forms();
    s_edge();
    s_reg();
    s_secure();
    s_standby();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    s_reset();
    end_sim();
  end
endmodule // tb_top
